// [verilog/swep_pkg.sv]
// package: register map, field layout and encodings for the overlay end setup
`default_nettype none
package swep_pkg;
	// register offsets in the device map
	localparam logic [7:0] HEND_LOW_OFS  = 8'h8C;
	localparam logic [7:0] HEND_HIGH_OFS = 8'h8D;
	localparam logic [7:0] VEND_LOW_OFS  = 8'h90;
	localparam logic [7:0] VEND_HIGH_OFS = 8'h91;
	localparam logic [7:0] DISP_MODE_OFS = 8'h71;
	// field layout
	localparam int POS_W        = 10;
	localparam int HIGH_LSB     = 8;
	localparam int OVL_EN_BIT   = 4;
	localparam int WORD_BITS    = 32;
	// reset values
	localparam logic [7:0] DISP_MODE_RST = 8'h00;
	localparam logic [POS_W-1:0] POS_RST = 10'h000;

	typedef enum logic [1:0] {
		SWEP_ROT_0,
		SWEP_ROT_90,
		SWEP_ROT_180,
		SWEP_ROT_270
	} swep_rot_t;

	typedef enum logic [2:0] {
		SWEP_BPP_1,
		SWEP_BPP_2,
		SWEP_BPP_4,
		SWEP_BPP_8,
		SWEP_BPP_16
	} swep_bpp_t;

	// one overlay placement order from the user side
	typedef struct packed {
		swep_rot_t        rot;
		swep_bpp_t        bpp;
		logic [POS_W-1:0] panel_w;
		logic [POS_W-1:0] panel_h;
		logic [POS_W-1:0] x2;
		logic [POS_W-1:0] y2;
	} swep_req_t;

	// one byte write toward the device
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} swep_wr_t;
endpackage
`default_nettype wire

// [verilog/swep_calc.sv]
// end-setting arithmetic: turns a corner and a panel into register values
`timescale 1ns/10ps
`default_nettype none
module swep_calc (
	input  wire swep_pkg::swep_req_t         req,
	output logic [swep_pkg::POS_W-1:0]       hend,
	output logic [swep_pkg::POS_W-1:0]       vend
);
	// log2 of pixels per 32-bit word at each depth
	function automatic logic [2:0] grp_shift(input swep_pkg::swep_bpp_t b);
		case (b)
			swep_pkg::SWEP_BPP_1:  grp_shift = 3'h5;
			swep_pkg::SWEP_BPP_2:  grp_shift = 3'h4;
			swep_pkg::SWEP_BPP_4:  grp_shift = 3'h3;
			swep_pkg::SWEP_BPP_8:  grp_shift = 3'h2;
			default:               grp_shift = 3'h1;
		endcase
	endfunction

	logic [2:0]                  sh;
	logic [swep_pkg::POS_W-1:0]  wx;
	logic [swep_pkg::POS_W-1:0]  hx;
	logic [swep_pkg::POS_W-1:0]  gx;

	// values are truncated groups; a coordinate off the group grid drops its
	// remainder, so software must keep it aligned
	always_comb begin
		sh = grp_shift(req.bpp);
		wx = req.panel_w - req.x2;
		hx = req.panel_h - req.x2;
		// x as a whole group index, the count a start setting takes as is
		gx = req.x2 >> sh;
		case (req.rot)
			swep_pkg::SWEP_ROT_90: begin
				hend = req.y2 - 10'h001;
				vend = (hx >> sh) - 10'h001;
			end
			swep_pkg::SWEP_ROT_180: begin
				hend = (wx >> sh) - 10'h001;
				vend = req.panel_h - req.y2 - 10'h001;
			end
			swep_pkg::SWEP_ROT_270: begin
				hend = req.panel_w - req.y2 - 10'h001;
				vend = gx - 10'h001;
			end
			default: begin
				hend = gx - 10'h001;
				vend = req.y2 - 10'h001;
			end
		endcase
	end
endmodule // swep_calc
`default_nettype wire

// [verilog/swep_ctrl.sv]
// host controller that programs the overlay end settings and enables it
// Notes on behaviour
// - 0 degrees: horizontal end is x over group size minus one.
// - 90 degrees: horizontal end is y minus one.
// - 180 degrees: horizontal end is (width minus x) over group minus one.
// - 270 degrees: horizontal end is width minus y minus one.
// - 0 degrees: vertical end is y minus one.
// - 90 degrees: vertical end is (height minus x) over group minus one.
// - 180 degrees: vertical end is height minus y minus one.
// - 270 degrees: vertical end is x over group minus one.
// - x must be a multiple of the group size.
// - at 180 degrees width minus x must be group aligned.
// - at 90 degrees height minus x must be group aligned.
// - overlay enable bit 4 of mode register is set after positions.
// - horizontal start at 0 degrees has no minus one.
`timescale 1ns/10ps
`default_nettype none
module swep_ctrl (
	input  wire logic                  clk,
	input  wire logic                  reset_n,
	// user side
	input  wire logic                  start,
	input  wire swep_pkg::swep_req_t   req,
	input  wire logic [7:0]            mode_base,
	output logic                       busy,
	output logic                       done,
	// device register port
	output logic                       wr_en,
	output swep_pkg::swep_wr_t         wr,
	input  wire logic                  wr_ack
);
	typedef enum logic [2:0] {
		SWEP_IDLE,
		SWEP_HLO,
		SWEP_HHI,
		SWEP_VLO,
		SWEP_VHI,
		SWEP_MODE
	} swep_state_t;

	// ==========================================================
	// arithmetic
	logic [swep_pkg::POS_W-1:0] hend_c;
	logic [swep_pkg::POS_W-1:0] vend_c;

	swep_calc u_calc (
		.req  (req),
		.hend (hend_c),
		.vend (vend_c)
	);

	// ==========================================================
	// sequencer
	swep_state_t                state;
	swep_state_t                next_state;
	logic [swep_pkg::POS_W-1:0] hend;
	logic [swep_pkg::POS_W-1:0] next_hend;
	logic [swep_pkg::POS_W-1:0] vend;
	logic [swep_pkg::POS_W-1:0] next_vend;
	logic [7:0]                 mode;
	logic [7:0]                 next_mode;
	logic                       next_busy;
	logic                       next_done;
	logic                       next_wr_en;
	swep_pkg::swep_wr_t         next_wr;

	// high byte: bits 9:8 in the two low bits, rest zero
	function automatic logic [7:0] hi_byte(
		input logic [swep_pkg::POS_W-1:0] v);
		hi_byte = {6'h00, v[swep_pkg::POS_W-1:swep_pkg::HIGH_LSB]};
	endfunction

	// a start counts only in idle; orders that arrive while busy are
	// dropped, not queued, so the user must wait for done
	logic                       take;
	// a write leaves the port at the edge where both sides agree
	logic                       acc;

	assign take = (state == SWEP_IDLE) && start;
	assign acc  = wr_en && wr_ack;

	// ==========================================================
	// captured order
	// settings freeze at the start edge, so req may change while busy
	// without tearing a low byte from its high byte
	always_comb begin
		next_hend = hend;
		next_vend = vend;
		next_mode = mode;
		if (take) begin
			next_hend = hend_c;
			next_vend = vend_c;
			next_mode = mode_base;
		end
	end

	// captured order registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hend <= swep_pkg::POS_RST;
			vend <= swep_pkg::POS_RST;
			mode <= swep_pkg::DISP_MODE_RST;
		end else begin
			hend <= next_hend;
			vend <= next_vend;
			mode <= next_mode;
		end
	end

	// ==========================================================
	// step order
	// one state per register, advanced only by an accepted write; enable
	// goes last so the first order after reset never shows a half-programmed
	// corner; enable is never cleared, so later orders rewrite a live corner
	always_comb begin
		next_state = state;
		next_busy  = busy;
		next_done  = 1'b0;
		case (state)
			SWEP_IDLE: begin
				if (take) begin
					next_busy  = 1'b1;
					next_state = SWEP_HLO;
				end
			end
			SWEP_HLO: begin
				if (acc) begin
					next_state = SWEP_HHI;
				end
			end
			SWEP_HHI: begin
				if (acc) begin
					next_state = SWEP_VLO;
				end
			end
			SWEP_VLO: begin
				if (acc) begin
					next_state = SWEP_VHI;
				end
			end
			SWEP_VHI: begin
				if (acc) begin
					next_state = SWEP_MODE;
				end
			end
			SWEP_MODE: begin
				if (acc) begin
					next_busy  = 1'b0;
					next_done  = 1'b1;
					next_state = SWEP_IDLE;
				end
			end
			default: begin
				next_state = SWEP_IDLE;
				next_busy  = 1'b0;
			end
		endcase
	end

	// step order registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= SWEP_IDLE;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			state <= next_state;
			busy  <= next_busy;
			done  <= next_done;
		end
	end

	// ==========================================================
	// write port
	// one write held until acked; there is no timeout, so a device that
	// never acknowledges stalls the sequence here
	always_comb begin
		next_wr_en = wr_en;
		next_wr    = wr;
		case (state)
			SWEP_IDLE: begin
				if (take) begin
					next_wr_en = 1'b1;
					next_wr    = '{swep_pkg::HEND_LOW_OFS, hend_c[7:0]};
				end
			end
			SWEP_HLO: begin
				if (acc) begin
					next_wr = '{swep_pkg::HEND_HIGH_OFS, hi_byte(hend)};
				end
			end
			SWEP_HHI: begin
				if (acc) begin
					next_wr = '{swep_pkg::VEND_LOW_OFS, vend[7:0]};
				end
			end
			SWEP_VLO: begin
				if (acc) begin
					next_wr = '{swep_pkg::VEND_HIGH_OFS, hi_byte(vend)};
				end
			end
			SWEP_VHI: begin
				if (acc) begin
					next_wr = '{swep_pkg::DISP_MODE_OFS,
						mode | (8'h01 << swep_pkg::OVL_EN_BIT)};
				end
			end
			SWEP_MODE: begin
				if (acc) begin
					next_wr_en = 1'b0;
				end
			end
			default: begin
				next_wr_en = 1'b0;
			end
		endcase
	end

	// write port registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_en <= 1'b0;
			wr    <= '0;
		end else begin
			wr_en <= next_wr_en;
			wr    <= next_wr;
		end
	end
endmodule // swep_ctrl
`default_nettype wire

// [bench/swep_assertions.sv]
// checker: order and framing of the end-setting writes
`timescale 1ns/10ps
`default_nettype none
// ====
// controller port checker
module swep_assertions (
	input wire logic                clk,
	input wire logic                reset_n,
	input wire logic                start,
	input wire swep_pkg::swep_req_t req,
	input wire logic [7:0]          mode_base,
	input wire logic                busy,
	input wire logic                done,
	input wire logic                wr_en,
	input wire swep_pkg::swep_wr_t  wr,
	input wire logic                wr_ack
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// a write is taken on this edge
	wire acc = wr_en && wr_ack;
	first_write_a: assert property (start && !busy |=> wr_en && wr.addr == 8'h8C)
		else $error("first write wrong");
	hend_high_a: assert property (acc && wr.addr == 8'h8C |=> wr.addr == 8'h8D)
		else $error("hend high missing");
	vend_low_a: assert property (acc && wr.addr == 8'h8D |=> wr.addr == 8'h90)
		else $error("vend low missing");
	vend_high_a: assert property (acc && wr.addr == 8'h90 |=> wr.addr == 8'h91)
		else $error("vend high missing");
	enable_last_a: assert property (acc && wr.addr == 8'h91 |=> wr_en && wr.addr == 8'h71 && wr.data[4])
		else $error("enable write wrong");
	done_after_a: assert property (acc && wr.addr == 8'h71 |=> done && !wr_en && !busy)
		else $error("done not after enable");
	high_unused_a: assert property (wr_en && (wr.addr == 8'h8D || wr.addr == 8'h91) |-> wr.data[7:2] == 6'h00)
		else $error("unused high bits set");
	write_hold_a: assert property (wr_en && !wr_ack |=> wr_en && $stable(wr))
		else $error("write dropped before ack");
endmodule // swep_assertions
bind swep_ctrl swep_assertions i_chk (.clk(clk), .reset_n(reset_n),
	.start(start), .req(req), .mode_base(mode_base), .busy(busy),
	.done(done), .wr_en(wr_en), .wr(wr), .wr_ack(wr_ack));
`default_nettype wire

// [bench/swep_dev_model.sv]
// device model: end-setting and mode registers behind the write port
`timescale 1ns/10ps
`default_nettype none
// ====
// register file
module swep_dev_model (
	input wire logic               clk,
	input wire logic               reset_n,
	input wire logic               wr_en,
	input wire swep_pkg::swep_wr_t wr,
	input wire logic               slow,
	output logic                   wr_ack,
	output logic [9:0]             hend,
	output logic [9:0]             vend,
	output logic [7:0]             mode
);
	// slow holds the ack off so writes must wait
	assign wr_ack = wr_en && !slow;
	// high registers keep bits 9:8 only
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hend <= swep_pkg::POS_RST;
			vend <= swep_pkg::POS_RST;
			mode <= swep_pkg::DISP_MODE_RST;
		end else if (wr_ack) begin
			case (wr.addr)
			8'h8C: hend[7:0] <= wr.data;
			8'h8D: hend[9:8] <= wr.data[1:0];
			8'h90: vend[7:0] <= wr.data;
			8'h91: vend[9:8] <= wr.data[1:0];
			8'h71: mode <= wr.data;
			default: ;
			endcase
		end
	end
endmodule // swep_dev_model
`default_nettype wire

// [bench/tb_top.sv]
// testbench: random overlay corners, device copy checked against model
`timescale 1ns/10ps
`default_nettype none
// ====
// stimulus, scoreboard and verdict
module tb_top;
	logic                clk;
	logic                reset_n;
	logic                start;
	logic                slow;
	logic                busy;
	logic                done;
	logic                wr_en;
	logic                wr_ack;
	logic [7:0]          mode_base;
	logic [7:0]          mode;
	logic [9:0]          hend;
	logic [9:0]          vend;
	logic [31:0]         seed = 32'h9782;
	logic [27:0]         q[$];
	int                  err_total = 0;
	int                  compares = 0;
	int                  cyc = 0;
	swep_pkg::swep_req_t req;
	swep_pkg::swep_wr_t  wr;
	swep_ctrl i_dut (.clk(clk), .reset_n(reset_n), .start(start), .req(req),
		.mode_base(mode_base), .busy(busy), .done(done), .wr_en(wr_en),
		.wr(wr), .wr_ack(wr_ack));
	swep_dev_model i_dev (.clk(clk), .reset_n(reset_n), .wr_en(wr_en),
		.wr(wr), .slow(slow), .wr_ack(wr_ack), .hend(hend), .vend(vend),
		.mode(mode));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// expected {hend, vend}: p counts pixel groups, l counts lines
	function automatic logic [19:0] exp_of(swep_pkg::swep_req_t r);
		logic [9:0] p;
		logic [9:0] l;
		case (r.rot)
		2'h0: begin p = r.x2; l = r.y2; end
		2'h1: begin p = r.panel_h - r.x2; l = r.y2; end
		2'h2: begin p = r.panel_w - r.x2; l = r.panel_h - r.y2; end
		default: begin p = r.x2; l = r.panel_w - r.y2; end
		endcase
		// unused depth codes fall back to the two-pixel group
		p = (p >> ((int'(r.bpp) > 4) ? 1 : 5 - int'(r.bpp))) - 10'h001;
		l = l - 10'h001;
		return r.rot[0] ? {l, p} : {p, l};
	endfunction
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// mode register byte against its note
	task automatic chk_mode(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t mode got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one order; inputs scrambled while busy must not leak in
	task automatic run(input swep_pkg::swep_req_t r, input logic [7:0] m);
		@(posedge clk);
		q.push_back({exp_of(r), m | 8'h10});
		start <= 1'b1;
		req <= r;
		mode_base <= m;
		@(posedge clk);
		req.x2 <= ~r.x2;
		mode_base <= ~m;
		@(posedge clk);
		start <= 1'b0;
		do begin
			@(posedge clk);
			slow <= seed[0];
			void'(rnd());
			#1;
		end while (busy !== 1'b0);
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			$display("ERROR %0t timeout", $time);
			complete_run();
		end
	end
	// oldest note against the device copy when done shows
	always @(posedge clk) begin
		logic [27:0] e;
		if (reset_n === 1'b1 && done === 1'b1) begin
			e = q.pop_front();
			chk(hend, e[27:18]);
			chk(vend, e[17:8]);
			chk_mode(mode, e[7:0]);
		end
	end
	initial begin
		swep_pkg::swep_req_t r;
		logic [9:0] msk;
		reset_n = 1'b0;
		start = 1'b0;
		slow = 1'b0;
		req = '0;
		mode_base = 8'h00;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		r = {2'h0, 3'h2, 10'h140, 10'h0F0, 10'h0F0, 10'h0B4};
		run(r, 8'h00);
		// groups from the start at x=80 through the end, inclusive, span 20
		chk(hend - 10'h00A + 10'h001, 10'h014);
		r = {2'h0, 3'h4, 10'h140, 10'h0F0, 10'h000, 10'h000};
		run(r, 8'hEF);
		r = {2'h0, 3'h7, 10'h140, 10'h0F0, 10'h0F0, 10'h0B4};
		run(r, 8'h00);
		// every rotation and depth; x, width and height kept group aligned
		for (int k = 0; k < 20; k++) begin
			msk = 10'h3FF << (5 - k % 5);
			r = {2'(k / 5), 3'(k % 5), 10'(rnd()) & msk, 10'(rnd()) & msk,
				10'(rnd()) & msk, 10'(rnd())};
			run(r, 8'(rnd()));
		end
		repeat (3) @(posedge clk);
		if (q.size() != 0) begin
			err_total++;
			$display("ERROR %0t results missing", $time);
		end
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
